// *** core/tmr_regs.vh ***
// Register map, field positions and encodings of the 8-bit timer
`ifndef TMR_REGS_VH
`define TMR_REGS_VH

// Register byte addresses
`define TMR_ADDR_CTRL    8'h00
`define TMR_ADDR_COUNT   8'h04
`define TMR_ADDR_CMP     8'h08
`define TMR_ADDR_FLAG    8'h0c
`define TMR_ADDR_MASK    8'h10
`define TMR_ADDR_STAT    8'h14

// Control register fields
`define TMR_CS_LSB       0
`define TMR_CS_MSB       2
`define TMR_WGM_LSB      3
`define TMR_WGM_MSB      4
`define TMR_COM_LSB      5
`define TMR_COM_MSB      6
`define TMR_FOC_BIT      7

// Flag and mask register bits
`define TMR_OVF_BIT      0
`define TMR_CMP_BIT      1

// Clock select codes
`define TMR_CS_STOP      3'h0
`define TMR_CS_DIV1      3'h1
`define TMR_CS_DIV8      3'h2
`define TMR_CS_DIV64     3'h3
`define TMR_CS_DIV256    3'h4
`define TMR_CS_DIV1024   3'h5
`define TMR_CS_EXT_FALL  3'h6
`define TMR_CS_EXT_RISE  3'h7

// Highest prescaler bit that must be set for each division
`define TMR_TAP_DIV8     2
`define TMR_TAP_DIV64    5
`define TMR_TAP_DIV256   7
`define TMR_TAP_DIV1024  9

// Waveform modes
`define TMR_WGM_NORMAL   2'h0
`define TMR_WGM_PHASE    2'h1
`define TMR_WGM_CTC      2'h2
`define TMR_WGM_FAST     2'h3

// Compare output modes
`define TMR_COM_NONE     2'h0
`define TMR_COM_TOGGLE   2'h1
`define TMR_COM_CLEAR    2'h2
`define TMR_COM_SET      2'h3

// Counter extremes and reset values
`define TMR_BOTTOM       8'h00
`define TMR_MAX          8'hff
`define TMR_RST_BYTE     8'h00

`endif

// *** core/tmr_timer.v ***
// 8-bit timer/counter with one compare unit, PWM and an APB register slave
`timescale 1ns/100ps
`include "tmr_regs.vh"

module tmr_timer
#(
    parameter ADDR_W = 8,
    parameter PRE_W  = 10
)
(
    // APB slave
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // External clock pin
    input  wire              ext_clock_pin,
    // CPU interrupt handshake
    input  wire              global_irq_enable,
    input  wire              overflow_irq_ack,
    input  wire              compare_irq_ack,
    output reg               overflow_irq,
    output reg               compare_irq,
    // Waveform output
    output reg               compare_output
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    reg [2:0]       clock_select_field;
    reg [1:0]       waveform_mode_field;
    reg [1:0]       compare_output_mode_field;
    reg [7:0]       counter_value;
    reg [7:0]       compare_value;
    reg [7:0]       compare_buffer;
    reg             overflow_flag;
    reg             compare_flag;
    reg             overflow_irq_enable;
    reg             compare_irq_enable;
    reg             count_down;
    reg             match_block;
    reg [PRE_W-1:0] prescaler;
    reg             ext_sync1;
    reg             ext_sync2;
    reg             ext_prev;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Tick select from prescaler taps and external edges
    function tick_of;
        input [2:0]       sel;
        input [PRE_W-1:0] pre;
        input             rise;
        input             fall;
        begin
            case (sel)
                `TMR_CS_DIV1:     tick_of = 1'b1;
                `TMR_CS_DIV8:     tick_of = &pre[`TMR_TAP_DIV8:0];
                `TMR_CS_DIV64:    tick_of = &pre[`TMR_TAP_DIV64:0];
                `TMR_CS_DIV256:   tick_of = &pre[`TMR_TAP_DIV256:0];
                `TMR_CS_DIV1024:  tick_of = &pre[`TMR_TAP_DIV1024:0];
                `TMR_CS_EXT_FALL: tick_of = fall;
                `TMR_CS_EXT_RISE: tick_of = rise;
                default:          tick_of = 1'b0;
            endcase
        end
    endfunction

    // Non-PWM output action for a match or a forced match
    function oc_plain;
        input [1:0] com;
        input       oc;
        begin
            case (com)
                `TMR_COM_TOGGLE: oc_plain = ~oc;
                `TMR_COM_CLEAR:  oc_plain = 1'b0;
                `TMR_COM_SET:    oc_plain = 1'b1;
                default:         oc_plain = oc;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire apb_acc  = psel & penable & pready;
    wire apb_wr   = apb_acc & pwrite;
    wire wr_ctrl  = apb_wr & (paddr == `TMR_ADDR_CTRL);
    wire wr_count = apb_wr & (paddr == `TMR_ADDR_COUNT);
    wire wr_cmp   = apb_wr & (paddr == `TMR_ADDR_CMP);
    wire wr_flag  = apb_wr & (paddr == `TMR_ADDR_FLAG);
    wire wr_mask  = apb_wr & (paddr == `TMR_ADDR_MASK);
    wire pwm_mode = (waveform_mode_field == `TMR_WGM_PHASE) |
                    (waveform_mode_field == `TMR_WGM_FAST);
    wire force_cmp = wr_ctrl & pwdata[`TMR_FOC_BIT];

    // ------------------------------------------------------------
    // Timer tick
    // ------------------------------------------------------------
    wire ext_rise = ext_sync2 & ~ext_prev;
    wire ext_fall = ~ext_sync2 & ext_prev;
    wire timer_tick = tick_of(clock_select_field, prescaler, ext_rise, ext_fall);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescaler <= {PRE_W{1'b0}};
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev  <= 1'b0;
        end
        else
        begin
            prescaler <= prescaler + {{(PRE_W-1){1'b0}}, 1'b1};
            ext_sync1 <= ext_clock_pin;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
        end
    end

    // ------------------------------------------------------------
    // Counter sequence
    // ------------------------------------------------------------
    wire at_bottom = (counter_value == `TMR_BOTTOM);
    wire at_max    = (counter_value == `TMR_MAX);
    wire cmp_match = (counter_value == compare_value);
    wire live_match = timer_tick & cmp_match & ~match_block;

    reg [7:0] next_count;
    reg       next_down;
    reg       ovf_event;
    reg       load_buffer;
    always @*
    begin
        next_count  = counter_value;
        next_down   = count_down;
        ovf_event   = 1'b0;
        load_buffer = 1'b0;
        case (waveform_mode_field)
            `TMR_WGM_PHASE:
            begin
                if (!count_down && at_max)
                begin
                    next_down   = 1'b1;
                    next_count  = counter_value - 8'h01;
                    load_buffer = 1'b1;
                end
                else if (count_down && at_bottom)
                begin
                    next_down  = 1'b0;
                    next_count = counter_value + 8'h01;
                    ovf_event  = 1'b1;
                end
                else if (count_down)
                    next_count = counter_value - 8'h01;
                else
                    next_count = counter_value + 8'h01;
            end
            `TMR_WGM_CTC:
            begin
                next_down = 1'b0;
                if (cmp_match)
                    next_count = `TMR_BOTTOM;
                else
                    next_count = counter_value + 8'h01;
                ovf_event = at_max;
            end
            `TMR_WGM_FAST:
            begin
                next_down   = 1'b0;
                next_count  = counter_value + 8'h01;
                ovf_event   = at_max;
                load_buffer = at_max;
            end
            default:
            begin
                next_down  = 1'b0;
                next_count = counter_value + 8'h01;
                ovf_event  = at_max;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_value <= `TMR_RST_BYTE;
            count_down    <= 1'b0;
            match_block   <= 1'b0;
        end
        else
        begin
            if (wr_count)
            begin
                counter_value <= pwdata[7:0];
                match_block   <= 1'b1;
            end
            else if (timer_tick)
            begin
                counter_value <= next_count;
                count_down    <= next_down;
                match_block   <= 1'b0;
            end
            if (!wr_count && timer_tick == 1'b0 && !pwm_mode)
                count_down <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Compare register and buffer
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_value  <= `TMR_RST_BYTE;
            compare_buffer <= `TMR_RST_BYTE;
        end
        else
        begin
            if (wr_cmp)
                compare_buffer <= pwdata[7:0];
            if (wr_cmp && !pwm_mode)
                compare_value <= pwdata[7:0];
            else if (pwm_mode && timer_tick && load_buffer)
                compare_value <= compare_buffer;
        end
    end

    // ------------------------------------------------------------
    // Waveform output
    // ------------------------------------------------------------
    reg next_oc;
    always @*
    begin
        next_oc = compare_output;
        if (!pwm_mode)
        begin
            if (live_match || force_cmp)
                next_oc = oc_plain(compare_output_mode_field,
                                   compare_output);
        end
        else if (compare_output_mode_field[1])
        begin
            if (waveform_mode_field == `TMR_WGM_FAST)
            begin
                if (live_match)
                    next_oc = compare_output_mode_field[0];
                else if (timer_tick && at_max)
                    next_oc = ~compare_output_mode_field[0];
            end
            else if (live_match)
                next_oc = count_down ^ compare_output_mode_field[0];
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            compare_output <= 1'b0;
        else
            compare_output <= next_oc;
    end

    // ------------------------------------------------------------
    // Control, flags, masks, interrupts
    // ------------------------------------------------------------
    wire ovf_set = timer_tick & ovf_event;
    wire cmp_set = live_match;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_select_field        <= `TMR_CS_STOP;
            waveform_mode_field       <= `TMR_WGM_NORMAL;
            compare_output_mode_field <= `TMR_COM_NONE;
            overflow_flag             <= 1'b0;
            compare_flag              <= 1'b0;
            overflow_irq_enable       <= 1'b0;
            compare_irq_enable        <= 1'b0;
            overflow_irq              <= 1'b0;
            compare_irq               <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                clock_select_field        <= pwdata[`TMR_CS_MSB:`TMR_CS_LSB];
                waveform_mode_field       <= pwdata[`TMR_WGM_MSB:`TMR_WGM_LSB];
                compare_output_mode_field <= pwdata[`TMR_COM_MSB:`TMR_COM_LSB];
            end
            if (wr_mask)
            begin
                overflow_irq_enable <= pwdata[`TMR_OVF_BIT];
                compare_irq_enable  <= pwdata[`TMR_CMP_BIT];
            end
            if (ovf_set)
                overflow_flag <= 1'b1;
            else if (overflow_irq_ack || (wr_flag && pwdata[`TMR_OVF_BIT]))
                overflow_flag <= 1'b0;
            if (cmp_set)
                compare_flag <= 1'b1;
            else if (compare_irq_ack || (wr_flag && pwdata[`TMR_CMP_BIT]))
                compare_flag <= 1'b0;
            overflow_irq <= overflow_flag & overflow_irq_enable &
                            global_irq_enable & ~overflow_irq_ack;
            compare_irq  <= compare_flag & compare_irq_enable &
                            global_irq_enable & ~compare_irq_ack;
        end
    end

    // ------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------
    reg [7:0] rd_byte;
    reg       rd_hit;
    always @*
    begin
        rd_hit = 1'b1;
        case (paddr)
            `TMR_ADDR_CTRL:  rd_byte = {1'b0, compare_output_mode_field,
                                        waveform_mode_field, clock_select_field};
            `TMR_ADDR_COUNT: rd_byte = counter_value;
            `TMR_ADDR_CMP:   rd_byte = pwm_mode ? compare_buffer : compare_value;
            `TMR_ADDR_FLAG:  rd_byte = {6'h00, compare_flag, overflow_flag};
            `TMR_ADDR_MASK:  rd_byte = {6'h00, compare_irq_enable, overflow_irq_enable};
            `TMR_ADDR_STAT:  rd_byte = {5'h00, count_down, at_bottom, compare_output};
            default:
            begin
                rd_byte = `TMR_RST_BYTE;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (psel && penable && !pready)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                pslverr <= ~rd_hit;
            end
        end
    end

endmodule

// *** dv/tmr_cpu_model.sv ***
// Processor-side model that services timer interrupt requests
`timescale 1ns/100ps
module tmr_cpu_model
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Interrupt handshake
    input  wire logic service_en,
    input  wire logic overflow_irq,
    input  wire logic compare_irq,
    output logic      overflow_irq_ack,
    output logic      compare_irq_ack
);
    logic [1:0] holdoff;
    logic       go;

    assign go = service_en && (overflow_irq || compare_irq) && holdoff == 2'h0;

    // Holdoff keeps a request from being serviced twice while it drains
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overflow_irq_ack <= 1'b0;
            compare_irq_ack  <= 1'b0;
            holdoff          <= 2'h0;
        end
        else
        begin
            overflow_irq_ack <= go && overflow_irq;
            compare_irq_ack  <= go && !overflow_irq;
            if (go)
                holdoff <= 2'h3;
            else if (holdoff != 2'h0)
                holdoff <= holdoff - 2'h1;
        end
    end
endmodule

// *** dv/tmr_timer_asserts.sv ***
// Concurrent checks on the timer's bus and interrupt ports
`timescale 1ns/100ps
module tmr_timer_asserts
(
    // Bus side
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Interrupts and output
    input wire        global_irq_enable,
    input wire        overflow_irq,
    input wire        compare_irq,
    input wire        compare_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    access_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
        else $error("access phase did not end after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_access_a: assert property (pready |-> access_s)
        else $error("ready outside access phase");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    data_width_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    cmp_irq_gate_a: assert property (compare_irq |-> $past(global_irq_enable))
        else $error("compare irq without global enable");
    ovf_irq_gate_a: assert property (overflow_irq |-> $past(global_irq_enable))
        else $error("overflow irq without global enable");
    reset_state_a: assert property (!$past(presetn) |-> !compare_output && !compare_irq)
        else $error("output state not cleared by reset");
endmodule

bind tmr_timer tmr_timer_asserts u_tmr_timer_asserts
(
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .global_irq_enable (global_irq_enable),
    .overflow_irq      (overflow_irq),
    .compare_irq       (compare_irq),
    .compare_output    (compare_output)
);

// *** dv/tmr_timer_tb.sv ***
// Self-checking testbench for the 8-bit timer
`timescale 1ns/100ps
`include "tmr_regs.vh"
module tmr_timer_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        ext_clock_pin = 1'b0;
    logic        gie = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, ovf_ack, cmp_ack, ovf_irq, cmp_irq, cmp_out;
    logic [31:0] rd;
    logic        err;
    logic        last_out = 1'b0;
    logic        ovf_seen = 1'b0;
    logic        cmp_seen = 1'b0;
    int          n_fail = 0;
    int          check_count = 0;
    int          toggles = 0;
    int          highs = 0;

    always #50 pclk = ~pclk;
    always @(posedge pclk)
    begin
        toggles  <= toggles + int'(cmp_out !== last_out);
        last_out <= cmp_out;
        highs    <= highs + int'(cmp_out === 1'b1);
        ovf_seen <= ovf_seen | (ovf_irq === 1'b1);
        cmp_seen <= cmp_seen | (cmp_irq === 1'b1);
    end

    tmr_timer u_tmr_timer
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .ext_clock_pin     (ext_clock_pin),
        .global_irq_enable (gie),
        .overflow_irq_ack  (ovf_ack),
        .compare_irq_ack   (cmp_ack),
        .overflow_irq      (ovf_irq),
        .compare_irq       (cmp_irq),
        .compare_output    (cmp_out)
    );
    tmr_cpu_model u_tmr_cpu_model
    (
        .pclk             (pclk),
        .presetn          (presetn),
        .service_en       (1'b1),
        .overflow_irq     (ovf_irq),
        .compare_irq      (cmp_irq),
        .overflow_irq_ack (ovf_ack),
        .compare_irq_ack  (cmp_ack)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude;
    begin
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
    begin
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            n_fail++;
            conclude();
        end
    end
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    end
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [1:0] wgm,
                                        input logic [1:0] com, input logic foc);
        ctl = {24'h0, foc, com, wgm, cs};
    endfunction

    task automatic restart(input logic [31:0] cnt, input logic [31:0] c);
    begin
        apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
        apb(1'b1, `TMR_ADDR_COUNT, cnt);
        apb(1'b1, `TMR_ADDR_CTRL, c);
    end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
    begin
        for (int a = 0; a <= 20; a += 4)
            rdc("reset value", 8'(a), (a == 20) ? 32'h2 : 32'h0);
        apb(1'b1, 8'h18, 32'hff);
        chk("unmapped error", 32'h1, {31'h0, err});
        rdc("unmapped read", 8'h18, 32'h0);
        apb(1'b1, `TMR_ADDR_COUNT, 32'h1a5);
        rdc("counter width", `TMR_ADDR_COUNT, 32'ha5);
        apb(1'b1, `TMR_ADDR_CMP, 32'h3ff);
        rdc("compare width", `TMR_ADDR_CMP, 32'hff);
        apb(1'b1, `TMR_ADDR_MASK, 32'h3);
        rdc("mask bits", `TMR_ADDR_MASK, 32'h3);
    end
    endtask

    task automatic t_rate;
        logic [7:0] a;
    begin
        for (int i = 1; i <= 2; i++)
        begin
            restart(32'h0, ctl(3'(i), 2'h0, 2'h0, 1'b0));
            apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
            a = rd[7:0];
            repeat (8) apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
            chk("tick rate", {24'h0, a + ((i == 1) ? 8'd32 : 8'd4)}, rd);
        end
        apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
        apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
        a = rd[7:0];
        repeat (4) apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
        chk("stopped count", {24'h0, a}, rd);
    end
    endtask

    task automatic t_ext;
    begin
        for (int i = 6; i <= 7; i++)
        begin
            restart(32'h0, ctl(3'(i), 2'h0, 2'h0, 1'b0));
            repeat (10)
            begin
                repeat (4) @(posedge pclk);
                ext_clock_pin <= ~ext_clock_pin;
            end
            repeat (8) @(posedge pclk);
            rdc("ext edges", `TMR_ADDR_COUNT, 32'h5);
        end
    end
    endtask

    task automatic t_phase;
        logic [7:0] a;
    begin
        restart(32'hf0, ctl(3'h1, 2'h1, 2'h0, 1'b0));
        apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
        a = rd[7:0];
        repeat (6) apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
        apb(1'b0, `TMR_ADDR_STAT, 32'h0);
        chk("down flag", 32'h1, {31'h0, rd[2]});
        rdc("dual slope", `TMR_ADDR_COUNT, {24'h0, 8'hde - a});
    end
    endtask

    task automatic t_ctc;
        int  t;
        logic o;
    begin
        apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
        apb(1'b1, `TMR_ADDR_CMP, 32'h5);
        restart(32'h0, ctl(3'h1, 2'h2, 2'h1, 1'b0));
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
            if (i == 0)
                t = toggles;
            chk("ctc bound", 32'h1, {31'h0, rd <= 32'h5});
        end
        chk("match toggles", 32'h4, 32'(toggles - t));
        apb(1'b0, `TMR_ADDR_FLAG, 32'h0);
        chk("compare flag", 32'h1, {31'h0, rd[1]});
        apb(1'b1, `TMR_ADDR_CTRL, ctl(3'h1, 2'h2, 2'h0, 1'b0));
        apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
        t = toggles;
        repeat (5) apb(1'b0, `TMR_ADDR_COUNT, 32'h0);
        chk("no action", 32'h0, 32'(toggles - t));
        o = cmp_out;
        apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
        apb(1'b0, `TMR_ADDR_STAT, 32'h0);
        chk("kept output", {31'h0, o}, {31'h0, rd[0]});
    end
    endtask

    task automatic t_force;
    begin
        restart(32'h33, 32'h0);
        apb(1'b1, `TMR_ADDR_FLAG, 32'h3);
        for (int i = 3; i >= 1; i--)
        begin
            apb(1'b1, `TMR_ADDR_CTRL, ctl(3'h0, 2'h0, 2'(i), 1'b0));
            apb(1'b1, `TMR_ADDR_CTRL, ctl(3'h0, 2'h0, 2'(i), 1'b1));
            apb(1'b0, `TMR_ADDR_STAT, 32'h0);
            chk("forced output", {31'h0, i != 2}, {31'h0, rd[0]});
        end
        rdc("force flag", `TMR_ADDR_FLAG, 32'h0);
        rdc("force count", `TMR_ADDR_COUNT, 32'h33);
        rdc("strobe reads", `TMR_ADDR_CTRL, 32'h20);
        apb(1'b1, `TMR_ADDR_CMP, 32'h40);
        restart(32'h40, ctl(3'h1, 2'h0, 2'h0, 1'b0));
        rdc("blocked match", `TMR_ADDR_FLAG, 32'h0);
    end
    endtask

    task automatic t_fast;
        int h2;
        int h3;
    begin
        restart(32'h0, 32'h0);
        apb(1'b1, `TMR_ADDR_CTRL, ctl(3'h1, 2'h3, 2'h2, 1'b0));
        rdc("buffer read", `TMR_ADDR_CMP, 32'h40);
        repeat (300) @(posedge pclk);
        h2 = highs;
        repeat (256) @(posedge pclk);
        h2 = highs - h2;
        chk("duty", 32'h1, {31'h0, h2 >= 64 && h2 <= 66});
        apb(1'b1, `TMR_ADDR_CTRL, ctl(3'h1, 2'h3, 2'h3, 1'b0));
        repeat (300) @(posedge pclk);
        h3 = highs;
        repeat (256) @(posedge pclk);
        chk("inverted duty", 32'd256, 32'(h2 + highs - h3));
    end
    endtask

    task automatic t_irq;
        int n;
    begin
        apb(1'b1, `TMR_ADDR_MASK, 32'h1);
        apb(1'b1, `TMR_ADDR_CMP, 32'h40);
        restart(32'hf0, 32'h0);
        apb(1'b1, `TMR_ADDR_FLAG, 32'h3);
        apb(1'b1, `TMR_ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
        repeat (40) @(posedge pclk);
        apb(1'b0, `TMR_ADDR_FLAG, 32'h0);
        chk("overflow flag", 32'h1, {31'h0, rd[0]});
        chk("gated irq", 32'h0, {31'h0, ovf_seen});
        gie <= 1'b1;
        n = 0;
        while (ovf_seen !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        chk("irq raised", 32'h1, {31'h0, ovf_seen});
        repeat (8) @(posedge pclk);
        apb(1'b0, `TMR_ADDR_FLAG, 32'h0);
        chk("serviced", 32'h0, {31'h0, rd[0]});
        repeat (100) @(posedge pclk);
        chk("masked irq", 32'h0, {31'h0, cmp_seen});
        apb(1'b1, `TMR_ADDR_MASK, 32'h2);
        repeat (8) @(posedge pclk);
        chk("compare irq", 32'h1, {31'h0, cmp_seen});
        apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
        apb(1'b1, `TMR_ADDR_FLAG, 32'h3);
        rdc("one clears", `TMR_ADDR_FLAG, 32'h0);
    end
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rate();
        t_ext();
        t_phase();
        t_ctc();
        t_force();
        t_fast();
        t_irq();
        conclude();
    end
endmodule
